// File: core/tmc_cfg.svh
// register map, field positions, reset values and timing counts of the timer/counter
// assumes inclusion by bare name from the design modules and the bench
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

`define TMC_ADDR_W 8
`define TMC_OFF_CTRL 8'h00
`define TMC_OFF_CNT_LO 8'h04
`define TMC_OFF_CNT_HI 8'h08
`define TMC_OFF_IRQ_STAT 8'h0C
`define TMC_OFF_IRQ_CLR 8'h10
`define TMC_OFF_IRQ_EN 8'h14

`define TMC_BIT_RUN 0
`define TMC_BIT_CS 1
`define TMC_BIT_SYNC 2
`define TMC_BIT_OSCEN 3
`define TMC_BIT_PS_LO 4
`define TMC_BIT_PS_HI 5
`define TMC_BIT_RUNFLAG 6
`define TMC_BIT_WIDE 7
`define TMC_CTRL_WMASK 8'hBF
`define TMC_CTRL_RESET 8'h00
`define TMC_IRQ_OVF 0

`define TMC_CLK_HZ 50000000
`define TMC_INSTR_DIV 4
`define TMC_PS_MAX 7

`endif

// File: core/tmc_pkg.sv
// types shared by the timer/counter modules
// assumes tmc_cfg.svh on the include path
package tmc_pkg;

	// =========================================
	// control register layout
	typedef struct packed {
		logic wide;       // bit 7
		logic run_flag;   // bit 6, read only
		logic [1:0] presc;
		logic osc_en;
		logic sync_bypass;
		logic cs;
		logic run;        // bit 0
	} tmc_ctrl_t;

	// =========================================
	// pin-side signals after synchronising
	typedef struct packed {
		logic sysclk_flag;
		logic [1:0] port_pin;
		logic osc_in;
		logic ext_clk;
	} tmc_pins_t;

endpackage : tmc_pkg

// File: core/tmc_sync.sv
// two-flop synchroniser for a group of pin-side levels
// assumes inputs asynchronous to clk
`timescale 1ns/100ps
module tmc_sync #(
	parameter int W = 5
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic [W-1:0] d, // raw levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : tmc_sync

// File: core/tmc_prescale.sv
// 1:1 to 1:8 prescaler; passes every 2^sel-th input pulse
// assumes one-cycle input pulses on clk
`timescale 1ns/100ps
`include "tmc_cfg.svh"
module tmc_prescale #(
	parameter int W = 3
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic clr, // clear prescale count
	input wire logic in_pulse, // count clock pulse
	input wire logic [1:0] sel, // division select
	output logic out_pulse, // divided pulse, combinational
	output logic [W-1:0] cnt // prescale count
);
	logic [W-1:0] mask;
	logic [W-1:0] cnt_q;

	always_comb begin
		case (sel)
			2'h0: mask = W'(0);
			2'h1: mask = W'(1);
			2'h2: mask = W'(3);
			default: mask = W'(`TMC_PS_MAX);
		endcase
	end

	assign out_pulse = in_pulse && ((cnt_q & mask) == mask);
	assign cnt = cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (clr) begin
			cnt_q <= '0;
		end else if (in_pulse) begin
			cnt_q <= (cnt_q & mask) == mask ? '0 : cnt_q + W'(1);
		end
	end

	a_div_eight: assert property (@(posedge clk) disable iff (rst)
		(sel == 2'h3 && out_pulse) |-> cnt_q == W'(`TMC_PS_MAX))
		else $error("prescale 1:8 passed a pulse early");
endmodule : tmc_prescale

// File: core/tmc_timer.sv
// 16-bit timer/counter with crystal oscillator stage and APB register slave
// assumes an APB master on clk; pins and the clock-source flag are asynchronous
//
// Overview of operation
// - count only while run_enable is set; hold value while clear
// - internal source counts once per instruction cycle, clock divided by four
// - external source counts rising edges of clock pin or own oscillator
// - ext_sync_bypass picks synchronised or direct counting; ignored on internal source
// - prescale_select divides the count clock by 1, 2, 4 or 8
// - crystal oscillator runs only while osc_enable is set
// - read-only flag shows system clock taken from this oscillator
// - wide access maps the high-byte address onto a buffer register
// - wide access: low-byte read copies live high byte into buffer
// - wide access: high write loads buffer; low write updates both bytes together
// - wide access: no direct path to the live high byte
// - low-byte write clears prescaler; high-byte write leaves it alone
// - while enabled, both oscillator pins are inputs and read as zero; the code forces this on run_enable, not on osc_enable
// - enabled oscillator keeps running in every power-managed mode
// - capture/compare special event trigger clears the count
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "tmc_cfg.svh"
module tmc_timer #(
	parameter int CNT_W = 16,
	parameter int PS_W = 3
) (
	input wire logic clk, // system clock, 50 MHz
	input wire logic rst, // async reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [`TMC_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic ext_clock_pin, // external count clock
	input wire logic osc_in_pin, // crystal input
	output logic osc_out_pin, // crystal amplifier output
	output logic osc_out_oe, // amplifier drive enable
	input wire logic [1:0] port_c_direction, // port direction bits, 1 = input
	input wire logic [1:0] port_c_out, // port output data
	output logic [1:0] port_c_oe, // port drive enable
	output logic [1:0] port_c_read, // port read value
	input wire logic sysclk_from_osc, // clock controller selects this oscillator
	input wire logic capture_compare_trig, // special event trigger pulse
	output logic irq // level interrupt
);
	// =========================================
	// registers and synchronised pins
	tmc_pkg::tmc_ctrl_t ctrl_q;
	tmc_pkg::tmc_pins_t pins_raw;
	tmc_pkg::tmc_pins_t pins_s;
	logic [CNT_W-1:0] count_q;
	logic [7:0] hbuf_q;
	logic [1:0] div_q;
	logic cyc_en_q;
	logic ext_prev_q;
	logic ext_pend_q;
	logic irq_stat_q;
	logic irq_en_q;
	logic run_flag_q;

	assign pins_raw = '{sysclk_flag: sysclk_from_osc, port_pin: {osc_in_pin, ext_clock_pin},
		osc_in: osc_in_pin, ext_clk: ext_clock_pin};

	tmc_sync #(.W(5)) u_sync (
		.clk(clk),
		.rst(rst),
		.d(pins_raw),
		.q(pins_s)
	);

	// =========================================
	// apb decode
	logic acc;
	logic wr_ctrl;
	logic wr_lo;
	logic wr_hi;
	logic rd_lo;
	logic wr_clr;
	logic wr_en;
	logic mapped;

	assign acc = psel && penable && pready;
	assign wr_ctrl = acc && pwrite && paddr == `TMC_OFF_CTRL;
	assign wr_lo = acc && pwrite && paddr == `TMC_OFF_CNT_LO;
	assign wr_hi = acc && pwrite && paddr == `TMC_OFF_CNT_HI;
	assign rd_lo = acc && !pwrite && paddr == `TMC_OFF_CNT_LO;
	assign wr_clr = acc && pwrite && paddr == `TMC_OFF_IRQ_CLR;
	assign wr_en = acc && pwrite && paddr == `TMC_OFF_IRQ_EN;

	always_comb begin
		case (paddr)
			`TMC_OFF_CTRL, `TMC_OFF_CNT_LO, `TMC_OFF_CNT_HI,
			`TMC_OFF_IRQ_STAT, `TMC_OFF_IRQ_CLR, `TMC_OFF_IRQ_EN: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (psel && penable && !pready && !pwrite) begin
			case (paddr)
				`TMC_OFF_CTRL: prdata <= {24'h000000, ctrl_q};
				`TMC_OFF_CNT_LO: prdata <= {24'h000000, count_q[7:0]};
				`TMC_OFF_CNT_HI: prdata <= {24'h000000,
					ctrl_q.wide ? hbuf_q : count_q[15:8]};
				`TMC_OFF_IRQ_STAT: prdata <= {31'h00000000, irq_stat_q};
				`TMC_OFF_IRQ_EN: prdata <= {31'h00000000, irq_en_q};
				default: prdata <= '0;
			endcase
		end
	end

	a_wide_hi_read: assert property (@(posedge clk) disable iff (rst)
		(psel && penable && !pready && !pwrite && paddr == `TMC_OFF_CNT_HI && ctrl_q.wide)
		|=> prdata[7:0] == $past(hbuf_q))
		else $error("wide high read did not return the buffer");

	// =========================================
	// control register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `TMC_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= (pwdata[7:0] & `TMC_CTRL_WMASK) | {1'b0, run_flag_q, 6'h00};
		end else begin
			ctrl_q.run_flag <= run_flag_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_flag_q <= 1'b0;
		end else begin
			run_flag_q <= pins_s.sysclk_flag;
		end
	end

	// =========================================
	// instruction-cycle enable, clock / 4
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= '0;
			cyc_en_q <= 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			cyc_en_q <= div_q == 2'(`TMC_INSTR_DIV - 1);
		end
	end

	// =========================================
	// count source selection
	logic ext_lvl;
	logic ext_rise;
	logic src_pulse;
	logic tick;
	logic [PS_W-1:0] ps_cnt;

	assign ext_lvl = ctrl_q.osc_en ? pins_s.osc_in : pins_s.ext_clk;
	assign ext_rise = ext_lvl && !ext_prev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_lvl;
		end
	end

	// synchronised mode holds an edge until the next instruction cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_pend_q <= 1'b0;
		end else if (cyc_en_q) begin
			ext_pend_q <= 1'b0;
		end else if (ext_rise) begin
			ext_pend_q <= 1'b1;
		end
	end

	always_comb begin
		if (!ctrl_q.cs) begin
			src_pulse = cyc_en_q;
		end else if (ctrl_q.sync_bypass) begin
			src_pulse = ext_rise;
		end else begin
			src_pulse = cyc_en_q && (ext_pend_q || ext_rise);
		end
	end

	tmc_prescale #(.W(PS_W)) u_ps (
		.clk(clk),
		.rst(rst),
		.clr(wr_lo),
		.in_pulse(src_pulse && ctrl_q.run),
		.sel(ctrl_q.presc),
		.out_pulse(tick),
		.cnt(ps_cnt)
	);

	a_int_ignores: assert property (@(posedge clk) disable iff (rst)
		!ctrl_q.cs |-> src_pulse == cyc_en_q)
		else $error("internal source not tied to instruction cycle");
	a_async_edge: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q.cs && ctrl_q.sync_bypass && ext_rise) |-> src_pulse)
		else $error("unsynchronised edge not counted at once");
	a_ps_clear: assert property (@(posedge clk) disable iff (rst)
		wr_lo |=> ps_cnt == '0)
		else $error("low write did not clear prescaler");

	// =========================================
	// counter and high-byte buffer
	logic ovf;
	assign ovf = tick && !capture_compare_trig && !wr_lo && !wr_hi && (&count_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
		end else if (capture_compare_trig) begin
			count_q <= '0;
		end else if (wr_lo) begin
			count_q[7:0] <= pwdata[7:0];
			if (ctrl_q.wide) begin
				count_q[15:8] <= hbuf_q;
			end
		end else if (wr_hi) begin
			if (!ctrl_q.wide) begin
				count_q[15:8] <= pwdata[7:0];
			end
		end else if (tick) begin
			count_q <= count_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hbuf_q <= '0;
		end else if (ctrl_q.wide && wr_hi) begin
			hbuf_q <= pwdata[7:0];
		end else if (ctrl_q.wide && rd_lo) begin
			hbuf_q <= count_q[15:8];
		end
	end

	sequence s_idle_cycle;
		!ctrl_q.run && !capture_compare_trig && !wr_lo && !wr_hi;
	endsequence

	a_halt_holds: assert property (@(posedge clk) disable iff (rst)
		s_idle_cycle |=> count_q == $past(count_q))
		else $error("count moved while halted");
	a_int_rate: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q.run && !ctrl_q.cs && ctrl_q.presc == 2'h0 && cyc_en_q
		&& !capture_compare_trig && !wr_lo && !wr_hi)
		|=> count_q == $past(count_q) + CNT_W'(1) ##1 count_q == $past(count_q, 2) + CNT_W'(1))
		else $error("internal count rate wrong");
	a_rd_latch: assert property (@(posedge clk) disable iff (rst)
		(rd_lo && ctrl_q.wide && !wr_hi) |=> hbuf_q == $past(count_q[15:8]))
		else $error("low read did not latch high byte");
	a_wide_write: assert property (@(posedge clk) disable iff (rst)
		(wr_lo && ctrl_q.wide && !capture_compare_trig)
		|=> count_q == {$past(hbuf_q), $past(pwdata[7:0])})
		else $error("wide low write did not load both bytes");
	a_trig_clear: assert property (@(posedge clk) disable iff (rst)
		capture_compare_trig |=> count_q == '0)
		else $error("special event did not clear count");

	// =========================================
	// overflow interrupt: set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_q <= 1'b0;
		end else if (ovf) begin
			irq_stat_q <= 1'b1;
		end else if (wr_clr && pwdata[`TMC_IRQ_OVF]) begin
			irq_stat_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_en_q <= 1'b0;
		end else if (wr_en) begin
			irq_en_q <= pwdata[`TMC_IRQ_OVF];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= (irq_stat_q || ovf) && irq_en_q;
		end
	end

	a_ovf_sticky: assert property (@(posedge clk) disable iff (rst)
		ovf |=> irq_stat_q ##1 irq_stat_q || $past(wr_clr))
		else $error("overflow flag not set or lost");

	// =========================================
	// oscillator stage and pin ownership
	// amplifier follows osc_enable only, so it runs through every power mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_out_pin <= 1'b0;
			osc_out_oe <= 1'b0;
		end else begin
			osc_out_pin <= ctrl_q.osc_en && !pins_s.osc_in;
			osc_out_oe <= ctrl_q.osc_en;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_c_oe <= 2'h0;
			port_c_read <= 2'h0;
		end else if (ctrl_q.run) begin
			port_c_oe <= 2'h0;
			port_c_read <= 2'h0;
		end else begin
			port_c_oe <= ~port_c_direction;
			port_c_read <= port_c_direction & pins_s.port_pin | ~port_c_direction & port_c_out;
		end
	end

	a_osc_off: assert property (@(posedge clk) disable iff (rst)
		!ctrl_q.osc_en |=> !osc_out_oe && !osc_out_pin)
		else $error("oscillator drives while disabled");
	a_pins_input: assert property (@(posedge clk) disable iff (rst)
		ctrl_q.run |=> port_c_oe == 2'h0 && port_c_read == 2'h0)
		else $error("port pins not forced to input");
endmodule : tmc_timer

// File: test/tmc_src_model.sv
// pin-side model: external clock source and crystal, both with a 6-clk period
// assumes bench raises en only while it wants edges
`timescale 1ns/100ps
module tmc_src_model (
	input wire logic clk, // system clock
	input wire logic en, // source running
	input wire logic osc_oe, // amplifier drive from block
	output logic ext_pin, // external count clock
	output logic osc_pin, // crystal input
	output int n_ext, // rising edges sent on ext_pin
	output int n_osc // rising edges sent on osc_pin
);
	// =========================================
	// 3 clk high, 3 clk low per period
	int ph;
	initial begin
		ph = 0;
		ext_pin = 1'b0;
		osc_pin = 1'b0;
		n_ext = 0;
		n_osc = 0;
	end
	always @(posedge clk) begin
		ph <= (ph == 5) ? 0 : ph + 1;
		if (ph == 0) begin
			ext_pin <= en && !osc_oe;
			osc_pin <= en && osc_oe;
			n_ext <= n_ext + int'(en && !osc_oe);
			n_osc <= n_osc + int'(en && osc_oe);
		end else if (ph == 3) begin
			ext_pin <= 1'b0;
			osc_pin <= 1'b0;
		end
	end
endmodule : tmc_src_model

// File: test/tb_top.sv
// self-checking bench of the timer/counter over APB
// assumes design register map from tmc_cfg.svh
`timescale 1ns/100ps
`include "tmc_cfg.svh"
module tb_top;
	localparam logic [7:0] A_C = `TMC_OFF_CTRL;
	localparam logic [7:0] A_L = `TMC_OFF_CNT_LO;
	localparam logic [7:0] A_H = `TMC_OFF_CNT_HI;
	localparam logic [7:0] A_S = `TMC_OFF_IRQ_STAT;
	localparam logic [7:0] A_X = `TMC_OFF_IRQ_CLR;
	localparam logic [7:0] A_E = `TMC_OFF_IRQ_EN;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err, irq;
	logic src_en, sysclk, trig, ext_pin, osc_pin, osc_oe, osc_out;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [1:0] dir, pout, pc_oe, pc_rd;
	int n_errors = 0;
	int n_checks = 0;
	int n_ext, n_osc, base, cyc = 0;

	tmc_timer u_tmc_timer (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_pin),
		.osc_in_pin(osc_pin), .osc_out_pin(osc_out), .osc_out_oe(osc_oe),
		.port_c_direction(dir), .port_c_out(pout), .port_c_oe(pc_oe),
		.port_c_read(pc_rd), .sysclk_from_osc(sysclk),
		.capture_compare_trig(trig), .irq(irq));
	tmc_src_model u_tmc_src_model (.clk(clk), .en(src_en), .osc_oe(osc_oe),
		.ext_pin(ext_pin), .osc_pin(osc_pin), .n_ext(n_ext), .n_osc(n_osc));

	// =========================================
	// bus and check tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic conclude;
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	// =========================================
	// scenarios
	task automatic t_reset;
		rdc(A_C, 32'h0);
		rdc(A_L, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask : t_reset
	task automatic t_internal;
		for (int p = 0; p < 4; p++) begin
			wr(A_L, 32'h0);
			wr(A_C, {26'h0, p[1:0], 1'b0, p[0], 2'b01});
			wt(64);
			if (p == 0) begin
				chk({30'h0, pc_oe}, 32'h0);
				chk({30'h0, pc_rd}, 32'h0);
			end
			wr(A_C, 32'h0);
			apb(1'b0, A_L, 32'h0);
			v = rd;
			chk({31'h0, v inside {[(17 >> p) - 1:(17 >> p) + 1]}}, 32'h1);
			wt(20);
			rdc(A_L, v);
		end
		chk({30'h0, pc_oe}, 32'h3);
		chk({30'h0, pc_rd}, 32'h2);
	endtask : t_internal
	task automatic t_wide;
		wr(A_C, 32'h80);
		wr(A_H, 32'h5A);
		wr(A_C, 32'h0);
		rdc(A_H, 32'h0);
		wr(A_C, 32'h80);
		wr(A_L, 32'h34);
		wr(A_C, 32'h0);
		rdc(A_H, 32'h5A);
		rdc(A_L, 32'h34);
		wr(A_H, 32'h77);
		wr(A_C, 32'h80);
		rdc(A_H, 32'h5A);
		rdc(A_L, 32'h34);
		rdc(A_H, 32'h77);
		wr(A_C, 32'h0);
	endtask : t_wide
	task automatic t_ovf;
		wr(A_H, 32'hFF);
		wr(A_L, 32'hFE);
		wr(A_E, 32'h0);
		wr(A_C, 32'h01);
		wt(20);
		wr(A_C, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rdc(A_S, 32'h1);
		rdc(A_H, 32'h0);
		wr(A_E, 32'h1);
		wt(2);
		chk({31'h0, irq}, 32'h1);
		wr(A_X, 32'h1);
		wt(2);
		chk({31'h0, irq}, 32'h0);
		rdc(A_S, 32'h0);
	endtask : t_ovf
	task automatic t_trig;
		wr(A_L, 32'h55);
		wr(A_H, 32'h66);
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
		wt(2);
		rdc(A_L, 32'h0);
		rdc(A_H, 32'h0);
	endtask : t_trig
	task automatic t_ext;
		logic [7:0] ctl [3] = '{8'h03, 8'h07, 8'h0B};
		for (int m = 0; m < 3; m++) begin
			wr(A_L, 32'h0);
			if (m == 2) begin
				wr(A_C, 32'h08);
				wt(50);
				chk({31'h0, osc_oe}, 32'h1);
				chk({31'h0, osc_out}, 32'h1);
			end
			wr(A_C, {24'h0, ctl[m]});
			base = (m == 2) ? n_osc : n_ext;
			src_en <= 1'b1;
			wt(60);
			src_en <= 1'b0;
			wt(20);
			wr(A_C, 32'h0);
			rdc(A_L, ((m == 2) ? n_osc : n_ext) - base);
		end
		chk({31'h0, osc_oe}, 32'h0);
		chk({31'h0, osc_out}, 32'h0);
	endtask : t_ext
	task automatic t_flag;
		sysclk <= 1'b1;
		wt(5);
		wr(A_C, 32'h0);
		rdc(A_C, 32'h40);
		sysclk <= 1'b0;
		wt(5);
		wr(A_C, 32'h40);
		rdc(A_C, 32'h0);
	endtask : t_flag

	// =========================================
	// clock, timeout, main sequence
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, src_en, sysclk, trig} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		dir = 2'b00;
		pout = 2'b10;
		wt(2);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_internal();
		t_wide();
		t_ovf();
		t_trig();
		t_ext();
		t_flag();
		conclude();
	end
endmodule : tb_top
